// ---- design/gec_counter.v ----
`timescale 1ns/1ps
`include "gec_map.vh"
module gec_counter #(
    parameter WIDTH = 16,
    parameter EDGE_GATE_ONLY = 0,
    parameter DIV_W = 16
) (
    input wire clk, // System clock, 200 MHz.
    input wire rst_b, // Synchronous reset, active low.
    input wire [`GEC_ADDR_W-1:0] addr, // Register address.
    input wire [31:0] wdata, // Register write data.
    input wire wr, // Write strobe.
    input wire rd, // Read strobe.
    output reg [31:0] rdata, // Read data, one cycle after the strobe.
    input wire src_pin, // External source input.
    input wire tb_tick, // Internal timebase enable pulse.
    input wire gate_pin, // Gate input.
    input wire chain_in, // Previous counter terminal output.
    output reg count_out, // Counter output pin.
    output wire terminal_count, // One-cycle pulse at terminal event.
    output wire divided_clock_pin // Dedicated square wave output.
);
    localparam [WIDTH-1:0] CNT_MAX = {WIDTH{1'b1}};
    localparam [WIDTH-1:0] CNT_ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    reg [7:0] ctrl_r;
    reg armed_r;
    reg run_r;
    reg [WIDTH-1:0] count_r;
    reg src_d_r;
    reg gate_d_r;
    reg pulse_r;
    reg [1:0] sq_ctrl_r;
    reg [DIV_W-1:0] sq_div_r;
    reg sq_tb_d_r;
    reg [WIDTH-1:0] count_nxt;

    wire ext_sel = ctrl_r[`GEC_CTRL_EXTSRC];
    wire src_lvl = ext_sel ? src_pin : chain_in;
    wire src_rise = src_lvl & ~src_d_r;
    wire src_fall = ~src_lvl & src_d_r;
    wire tb_edge = ~ext_sel & tb_tick;
    // Internal source counts timebase ticks whenever no pin source is chosen, alongside chain edges of the selected polarity.
    wire src_evt = (ctrl_r[`GEC_CTRL_SRC_FALL] ? src_fall : src_rise) | tb_edge;
    wire [1:0] gmode_raw = ctrl_r[`GEC_CTRL_GMODE_HI:`GEC_CTRL_GMODE_LO];
    // The edge-gate-only variant has no level modes; a level request falls back to its edge twin.
    wire [1:0] gmode = EDGE_GATE_ONLY ? {1'b0, gmode_raw[0]} : gmode_raw;
    wire gate_rise = gate_pin & ~gate_d_r;
    wire gate_fall = ~gate_pin & gate_d_r;
    wire down = ctrl_r[`GEC_CTRL_DOWN];
    wire negpol = ctrl_r[`GEC_CTRL_NEGPOL];
    wire toggle = ctrl_r[`GEC_CTRL_TOGGLE];
    wire ungated = ctrl_r[`GEC_CTRL_UNGATED];
    wire [WIDTH-1:0] term_val = down ? {WIDTH{1'b0}} : CNT_MAX;

    reg gate_ok;
    always @* begin
        gate_ok = 1'b0;
        if (ungated) begin
            gate_ok = armed_r;
        end else begin
            case (gmode)
                `GEC_GM_RISE: gate_ok = run_r;
                `GEC_GM_FALL: gate_ok = run_r;
                `GEC_GM_HIGH: gate_ok = armed_r & gate_pin;
                `GEC_GM_LOW: gate_ok = armed_r & ~gate_pin;
                default: gate_ok = 1'b0;
            endcase
        end
    end

    // Gate state registered from last cycle so a gate change never qualifies an edge it follows.
    reg gate_ok_d_r;
    wire count_en = gate_ok & gate_ok_d_r & src_evt;
    wire term_hit = count_en & (count_nxt == term_val);
    assign terminal_count = term_hit;

    // Register write decode, one strobe per writable register and command bit.
    wire wr_ctrl = wr && (addr == `GEC_A_CTRL);
    wire wr_cmd = wr && (addr == `GEC_A_CMD);
    wire wr_count = wr && (addr == `GEC_A_COUNT);
    wire wr_sq_ctrl = wr && (addr == `GEC_A_SQ_CTRL);
    wire wr_sq_div = wr && (addr == `GEC_A_SQ_DIV);
    wire cmd_arm = wr_cmd && wdata[`GEC_CMD_ARM];
    wire cmd_disarm = wr_cmd && wdata[`GEC_CMD_DISARM];
    wire cmd_clear = wr_cmd && wdata[`GEC_CMD_CLEAR];
    wire gate_start = (gmode == `GEC_GM_RISE && gate_rise) || (gmode == `GEC_GM_FALL && gate_fall);

    always @* begin
        count_nxt = down ? count_r - CNT_ONE : count_r + CNT_ONE;
    end

    // Pin and gate history, sampled every cycle for the edge detectors.
    always @(posedge clk) begin
        if (!rst_b) begin
            src_d_r <= 1'b0;
            gate_d_r <= 1'b0;
            gate_ok_d_r <= 1'b0;
            sq_tb_d_r <= 1'b0;
        end else begin
            src_d_r <= src_lvl;
            gate_d_r <= gate_pin;
            gate_ok_d_r <= gate_ok;
            sq_tb_d_r <= src_pin;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= `GEC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata[7:0];
        end
    end

    // A control register write disarms, so a new mode never starts half-way.
    always @(posedge clk) begin
        if (!rst_b) begin
            armed_r <= 1'b0;
        end else if (wr_ctrl || cmd_disarm) begin
            armed_r <= 1'b0;
        end else if (cmd_arm) begin
            armed_r <= 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            run_r <= 1'b0;
        end else if (wr_ctrl || cmd_disarm) begin
            run_r <= 1'b0;
        end else if (!ungated && armed_r && !run_r && gate_start) begin
            run_r <= 1'b1;
        end
    end

    // A software load or clear wins over a counted edge in the same cycle.
    always @(posedge clk) begin
        if (!rst_b) begin
            count_r <= {WIDTH{1'b0}};
        end else if (wr_count) begin
            count_r <= wdata[WIDTH-1:0];
        end else if (cmd_clear) begin
            count_r <= {WIDTH{1'b0}};
        end else if (count_en) begin
            count_r <= count_nxt;
        end
    end

    // Pulse output rises at terminal count and falls on the next source edge, whether or not it is counted.
    always @(posedge clk) begin
        if (!rst_b) begin
            pulse_r <= 1'b0;
        end else if (wr_ctrl) begin
            pulse_r <= 1'b0;
        end else if (term_hit) begin
            pulse_r <= 1'b1;
        end else if (pulse_r && src_evt) begin
            pulse_r <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            count_out <= 1'b0;
        end else if (wr_ctrl) begin
            count_out <= wdata[`GEC_CTRL_NEGPOL];
        end else if (term_hit) begin
            if (toggle) begin
                count_out <= ~count_out;
            end else begin
                count_out <= ~negpol;
            end
        end else if (pulse_r && src_evt && !toggle) begin
            count_out <= negpol;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            sq_ctrl_r <= 2'h0;
        end else if (wr_sq_ctrl) begin
            sq_ctrl_r <= wdata[1:0];
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            sq_div_r <= `GEC_SQ_DIV_RST;
        end else if (wr_sq_div) begin
            sq_div_r <= wdata[DIV_W-1:0];
        end
    end

    // Reads only sample state, so the count is never disturbed.
    reg [31:0] rdata_nxt;
    always @* begin
        rdata_nxt = 32'h0;
        if (rd) begin
            case (addr)
                `GEC_A_CTRL: rdata_nxt[7:0] = ctrl_r;
                `GEC_A_COUNT: rdata_nxt[WIDTH-1:0] = count_r;
                `GEC_A_STATUS: rdata_nxt[3:0] = {count_out, gate_ok, run_r, armed_r};
                `GEC_A_SQ_CTRL: rdata_nxt[1:0] = sq_ctrl_r;
                `GEC_A_SQ_DIV: rdata_nxt[DIV_W-1:0] = sq_div_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    // Read data stands for one cycle only and returns to zero otherwise.
    always @(posedge clk) begin
        if (!rst_b) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rdata_nxt;
        end
    end

    // The square divider keeps its own copy of the pin so chaining cannot fake an edge.
    wire sq_src = sq_ctrl_r[`GEC_SQ_EXT] ? (src_pin & ~sq_tb_d_r) : tb_tick;

    gec_square_div #(
        .DIV_W(DIV_W)
    ) u_sq (
        .clk(clk),
        .rst_b(rst_b),
        .enable(sq_ctrl_r[`GEC_SQ_EN]),
        .tick(sq_src),
        .divisor(sq_div_r),
        .sq_out(divided_clock_pin)
    );
endmodule

// ---- common/gec_map.vh ----
`ifndef GEC_MAP_VH
`define GEC_MAP_VH
`define GEC_ADDR_W 4
`define GEC_A_CTRL 4'h0
`define GEC_A_CMD 4'h1
`define GEC_A_COUNT 4'h2
`define GEC_A_STATUS 4'h3
`define GEC_A_SQ_CTRL 4'h4
`define GEC_A_SQ_DIV 4'h5
`define GEC_CTRL_SRC_FALL 0
`define GEC_CTRL_DOWN 1
`define GEC_CTRL_GMODE_LO 2
`define GEC_CTRL_GMODE_HI 3
`define GEC_CTRL_UNGATED 4
`define GEC_CTRL_TOGGLE 5
`define GEC_CTRL_NEGPOL 6
`define GEC_CTRL_EXTSRC 7
`define GEC_CMD_ARM 0
`define GEC_CMD_DISARM 1
`define GEC_CMD_CLEAR 2
`define GEC_SQ_EN 0
`define GEC_SQ_EXT 1
`define GEC_GM_RISE 2'h0
`define GEC_GM_FALL 2'h1
`define GEC_GM_HIGH 2'h2
`define GEC_GM_LOW 2'h3
`define GEC_CTRL_RST 8'h00
`define GEC_SQ_DIV_RST 16'h0002
`endif

// ---- design/gec_square_div.v ----
`timescale 1ns/1ps
`include "gec_map.vh"
module gec_square_div #(
    parameter DIV_W = 16
) (
    input wire clk, // System clock.
    input wire rst_b, // Synchronous reset, active low.
    input wire enable, // Square wave enable.
    input wire tick, // One-cycle timebase enable.
    input wire [DIV_W-1:0] divisor, // Divisor, output frequency is tick rate over this.
    output reg sq_out // Divided square wave.
);
    reg [DIV_W-1:0] cnt_r;
    wire [DIV_W-1:0] half_lo = divisor >> 1;
    wire [DIV_W-1:0] half_hi = divisor - half_lo;
    wire [DIV_W-1:0] limit = sq_out ? half_lo : half_hi;

    // Each half period lasts a share of the divisor; odd divisors give a longer low half.
    always @(posedge clk) begin
        if (!rst_b || !enable) begin
            cnt_r <= {DIV_W{1'b0}};
            sq_out <= 1'b0;
        end else if (tick && divisor != {DIV_W{1'b0}}) begin
            if (cnt_r + {{(DIV_W-1){1'b0}}, 1'b1} >= limit) begin
                cnt_r <= {DIV_W{1'b0}};
                sq_out <= ~sq_out;
            end else begin
                cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// ---- bench/gec_counter_properties.sv ----
`timescale 1ns/1ps
`include "gec_map.vh"
module gec_counter_props #(
    parameter WIDTH = 16,
    parameter EDGE_GATE_ONLY = 0,
    parameter DIV_W = 16
) (
    input wire clk, // Clock.
    input wire rst_b, // Reset.
    input wire [`GEC_ADDR_W-1:0] addr, // Address.
    input wire [31:0] wdata, // Write data.
    input wire wr, // Write strobe.
    input wire rd, // Read strobe.
    input wire [31:0] rdata, // Read data.
    input wire src_pin, // Source.
    input wire tb_tick, // Timebase.
    input wire gate_pin, // Gate.
    input wire chain_in, // Chain source.
    input wire count_out, // Output pin.
    input wire terminal_count, // Terminal pulse.
    input wire divided_clock_pin // Square wave.
);
    reg tog_r;
    reg neg_r;
    reg src_d;
    reg chn_d;
    reg [2:0] edg_r;
    // Shadows the mode bits so output checks know toggle and polarity.
    always @(posedge clk) begin
        src_d <= src_pin;
        chn_d <= chain_in;
        edg_r <= {edg_r[1:0], (src_pin != src_d) | (chain_in != chn_d)};
        if (!rst_b) begin
            tog_r <= 1'b0;
            neg_r <= 1'b0;
        end else if (wr && addr == `GEC_A_CTRL) begin
            tog_r <= wdata[`GEC_CTRL_TOGGLE];
            neg_r <= wdata[`GEC_CTRL_NEGPOL];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_rd_idle; !$past(rd) |-> rdata == 32'h0; endproperty
    property p_tc_one; terminal_count |=> !terminal_count; endproperty
    property p_tc_edge; terminal_count |-> (src_pin != src_d) || (chain_in != chn_d) || tb_tick || (|edg_r); endproperty
    property p_tog; tog_r && terminal_count && !wr |=> count_out != $past(count_out); endproperty
    property p_pulse; !tog_r && !neg_r && terminal_count && !wr |=> count_out; endproperty
    property p_idle; wr && addr == `GEC_A_CTRL |=> count_out == neg_r; endproperty
    property p_rst; $rose(rst_b) |-> !count_out && !divided_clock_pin; endproperty
    property p_sq; $changed(divided_clock_pin) |-> $past(tb_tick) || $past(wr); endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_tc_one: assert property (p_tc_one) else $error("terminal pulse too long");
    a_tc_edge: assert property (p_tc_edge) else $error("terminal without edge");
    a_tog: assert property (p_tog) else $error("no toggle at terminal");
    a_pulse: assert property (p_pulse) else $error("no pulse at terminal");
    a_idle: assert property (p_idle) else $error("idle level wrong");
    a_rst: assert property (p_rst) else $error("outputs not clear");
    a_sq: assert property (p_sq) else $error("square moved without tick");
    c_tog: cover property (terminal_count && tog_r);
    c_pulse: cover property (terminal_count && !tog_r);
    c_sq: cover property ($rose(divided_clock_pin));
endmodule
bind gec_counter gec_counter_props #(.WIDTH(WIDTH), .EDGE_GATE_ONLY(EDGE_GATE_ONLY), .DIV_W(DIV_W)) u_props (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .src_pin(src_pin), .tb_tick(tb_tick), .gate_pin(gate_pin), .chain_in(chain_in),
    .count_out(count_out), .terminal_count(terminal_count), .divided_clock_pin(divided_clock_pin));

// ---- bench/gec_src_model.sv ----
`timescale 1ns/1ps
module gec_src_model (
    input wire clk, // Clock.
    output reg src_pin, // Source level.
    output reg gate_pin // Gate level.
);
    initial begin
        src_pin = 1'b0;
        gate_pin = 1'b0;
    end
    // Each level is held four cycles so every edge is seen as one event.
    task drive(input s, input g); begin
        @(posedge clk);
        src_pin <= s;
        gate_pin <= g;
        repeat (3) @(posedge clk);
    end endtask
    task edges(input integer n); integer i; begin
        for (i = 0; i < n; i = i + 1) begin
            drive(1'b0, gate_pin);
            drive(1'b1, gate_pin);
        end
    end endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
`include "gec_map.vh"
module tb;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg tb_tick = 1'b0;
    reg chain_in = 1'b0;
    integer tc_hits = 0;
    wire [31:0] rdata;
    wire src_pin, gate_pin, count_out, terminal_count, divided_clock_pin;
    integer mismatches = 0;
    integer tests_run = 0;
    integer sq_rises = 0;
    integer n;
    always #2.5 clk = ~clk;
    always @(posedge divided_clock_pin) sq_rises = sq_rises + 1;
    always @(posedge clk) if (terminal_count === 1'b1) tc_hits <= tc_hits + 1;
    gec_src_model u_src (.clk(clk), .src_pin(src_pin), .gate_pin(gate_pin));
    gec_counter u_dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_pin(src_pin), .tb_tick(tb_tick), .gate_pin(gate_pin), .chain_in(chain_in),
        .count_out(count_out), .terminal_count(terminal_count), .divided_clock_pin(divided_clock_pin));
    task chk(input string what, input [31:0] seen, input [31:0] exp); begin
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    end endtask
    task wr_reg(input [3:0] a, input [31:0] d); begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end endtask
    task rd_chk(input [3:0] a, input [31:0] exp); begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("reg", rdata, exp);
    end endtask
    task wrap_up; begin
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    end endtask
    initial begin
        #100000;
        mismatches = mismatches + 1;
        wrap_up;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`GEC_A_COUNT, 32'h0);
        rd_chk(`GEC_A_SQ_DIV, 32'h2);
        chk("out", count_out, 1'b0);
        wr_reg(`GEC_A_CTRL, 32'h90);
        wr_reg(`GEC_A_CMD, 32'h1);
        u_src.edges(5);
        rd_chk(`GEC_A_COUNT, 32'h5);
        rd_chk(`GEC_A_COUNT, 32'h5);
        wr_reg(`GEC_A_CTRL, 32'h91);
        wr_reg(`GEC_A_CMD, 32'h5);
        u_src.edges(4);
        rd_chk(`GEC_A_COUNT, 32'h4);
        for (n = 0; n < 4; n = n + 1) begin
            u_src.drive(1'b0, n[0]);
            wr_reg(`GEC_A_CTRL, 32'h80 | (n << 2));
            wr_reg(`GEC_A_CMD, 32'h5);
            u_src.edges(2);
            u_src.drive(1'b0, !n[0]);
            u_src.edges(3);
            rd_chk(`GEC_A_COUNT, 32'h3);
        end
        u_src.drive(1'b0, 1'b0);
        wr_reg(`GEC_A_CTRL, 32'h88);
        wr_reg(`GEC_A_CMD, 32'h5);
        u_src.drive(1'b1, 1'b0);
        u_src.drive(1'b1, 1'b1);
        u_src.edges(1);
        rd_chk(`GEC_A_COUNT, 32'h1);
        wr_reg(`GEC_A_CTRL, 32'h92);
        wr_reg(`GEC_A_COUNT, 32'h1);
        wr_reg(`GEC_A_CMD, 32'h1);
        u_src.edges(1);
        chk("out", count_out, 1'b1);
        u_src.drive(1'b0, 1'b1);
        chk("out", count_out, 1'b1);
        u_src.edges(1);
        chk("out", count_out, 1'b0);
        rd_chk(`GEC_A_COUNT, 32'hffff);
        wr_reg(`GEC_A_CTRL, 32'hb0);
        wr_reg(`GEC_A_CMD, 32'h1);
        for (n = 1; n < 3; n = n + 1) begin
            wr_reg(`GEC_A_COUNT, 32'hfffe);
            u_src.edges(1);
            chk("out", count_out, n[0]);
        end
        chk("tc", tc_hits, 32'h3);
        wr_reg(`GEC_A_CTRL, 32'h10);
        wr_reg(`GEC_A_CMD, 32'h5);
        for (n = 0; n < 2; n = n + 1) begin
            repeat (3) @(posedge clk);
            chain_in <= 1'b1;
            repeat (3) @(posedge clk);
            chain_in <= 1'b0;
        end
        rd_chk(`GEC_A_COUNT, 32'h2);
        wr_reg(`GEC_A_CTRL, 32'hc0);
        @(negedge clk);
        chk("out", count_out, 1'b1);
        wr_reg(`GEC_A_SQ_DIV, 32'h4);
        wr_reg(`GEC_A_SQ_CTRL, 32'h1);
        tb_tick <= 1'b1;
        repeat (8) @(posedge clk);
        sq_rises = 0;
        repeat (40) @(posedge clk);
        chk("sq", sq_rises, 32'ha);
        wr_reg(`GEC_A_SQ_CTRL, 32'h0);
        repeat (2) @(posedge clk);
        sq_rises = 0;
        repeat (40) @(posedge clk);
        chk("sq", sq_rises, 32'h0);
        rd_chk(4'hf, 32'h0);
        @(posedge clk);
        rst_b <= 1'b0;
        @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(`GEC_A_COUNT, 32'h0);
        chk("out", count_out, 1'b0);
        wrap_up;
    end
endmodule
